// file: hw/cisl_top.sv
// Interrupt entry, return and stack pointer sequencing with APB status.
// Assumes combinational memory read data and a sequencer that waits
// while seq_busy is high.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "cisl_params.svh"
module cisl_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_n_pin,
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_a_ddr,
  input wire logic [7:0] option_byte_two,
  input wire logic edge_only_opt,
  input wire logic capture_event_flag,
  input wire logic compare_match_flag,
  input wire logic counter_wrap_flag,
  input wire logic capture_ie,
  input wire logic compare_ie,
  input wire logic wrap_ie,
  input wire logic instr_boundary,
  input wire logic stack_pointer_reset_instr,
  input wire logic software_trap_instr,
  input wire logic return_from_service_instr,
  input wire logic push_byte,
  input wire logic pull_byte,
  input wire logic pc_inc,
  input wire logic pc_load,
  input wire logic [12:0] pc_load_value,
  input wire logic mask_set_instr,
  input wire logic mask_clear_instr,
  input wire logic [7:0] cpu_a,
  input wire logic [7:0] cpu_x,
  input wire logic [3:0] cpu_flags,
  input wire logic [7:0] mem_rdata,
  output logic [12:0] pc,
  output logic [12:0] stack_addr,
  output logic int_mask,
  output logic seq_busy,
  output logic irq_line,
  output logic [12:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic [7:0] rest_a,
  output logic [7:0] rest_x,
  output logic [3:0] rest_flags,
  output logic restore_done
);
  cisl_pkg::cisl_state_e state;
  cisl_pkg::cisl_addr_t vec;
  logic [5:0] sp;
  logic [2:0] step;
  logic phase;
  logic [3:0] clr_cnt;
  logic sw_clr;
  logic sw_sp_rst;
  logic cfg_done;
  logic edge_only_q;
  logic [7:0] pa_en_q;
  logic timer_req;
  logic hw_irq;
  logic idle;
  logic take_hw;
  logic take_swi;
  logic take_rti;
  logic irq_hi_read;
  logic [7:0] push_data;
  logic apb_acc;
  logic apb_wr;

  cisl_irq_if irq_bus();

  // ----------------------------------------------------------------
  // External interrupt latch
  // ----------------------------------------------------------------
  assign irq_bus.irq_n = irq_n_pin;
  assign irq_bus.pa = port_a_pins;
  assign irq_bus.pa_out = port_a_ddr;
  assign irq_bus.pa_en = pa_en_q;
  assign irq_bus.edge_only = edge_only_q;
  assign irq_bus.latch_clr = (clr_cnt == 4'd1) | sw_clr;

  cisl_irq_latch u_latch (
    .clk(pclk),
    .rst_n(presetn),
    .bus(irq_bus)
  );

  // Options are caught once after reset release and then frozen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_done <= 1'b0;
      edge_only_q <= 1'b1;
      pa_en_q <= 8'h00;
    end else if (!cfg_done) begin
      cfg_done <= 1'b1;
      edge_only_q <= edge_only_opt;
      pa_en_q <= option_byte_two;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_line <= 1'b1;
    end else begin
      irq_line <= irq_bus.line;
    end
  end

  // ----------------------------------------------------------------
  // Request qualification
  // ----------------------------------------------------------------
  assign timer_req = (capture_event_flag & capture_ie)
                   | (compare_match_flag & compare_ie)
                   | (counter_wrap_flag & wrap_ie);
  assign hw_irq = irq_bus.request;
  assign idle = (state == cisl_pkg::ST_IDLE);
  // Only sampled at boundaries, so a running instruction finishes
  assign take_hw = idle & instr_boundary & ~int_mask & (hw_irq | timer_req);
  assign take_swi = idle & software_trap_instr & ~take_hw;
  assign take_rti = idle & return_from_service_instr & ~take_hw
                  & ~software_trap_instr;
  assign irq_hi_read = (state == cisl_pkg::ST_VEC) & phase
                     & (step == 3'd0) & (vec == 13'(`CISL_VEC_IRQ));
  assign stack_addr = {`CISL_STACK_HI, sp};

  always_comb begin
    unique case (step)
      3'd0: push_data = pc[7:0];
      3'd1: push_data = {3'b000, pc[12:8]};
      3'd2: push_data = cpu_x;
      3'd3: push_data = cpu_a;
      default: push_data = {3'b111, cpu_flags[3], int_mask, cpu_flags[2:0]};
    endcase
  end

  // ----------------------------------------------------------------
  // Stack pointer
  // ----------------------------------------------------------------
  // Six bits only: overflow past 64 bytes wraps silently
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp <= `CISL_SP_RESET;
    end else if (state == cisl_pkg::ST_PUSH) begin
      sp <= sp - 6'd1;
    end else if (state == cisl_pkg::ST_PULL && !phase) begin
      sp <= sp + 6'd1;
    end else if (idle) begin
      if (stack_pointer_reset_instr || sw_sp_rst) begin
        sp <= `CISL_SP_RESET;
      end else if (push_byte) begin
        sp <= sp - 6'd1;
      end else if (pull_byte) begin
        sp <= sp + 6'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= 13'h0000;
    end else if (state == cisl_pkg::ST_VEC && phase) begin
      if (step == 3'd0) begin
        pc[12:8] <= mem_rdata[4:0];
      end else begin
        pc[7:0] <= mem_rdata;
      end
    end else if (state == cisl_pkg::ST_PULL && phase) begin
      if (step == 3'd3) begin
        pc[12:8] <= mem_rdata[4:0];
      end else if (step == `CISL_PULL_LAST) begin
        pc[7:0] <= mem_rdata;
      end
    end else if (idle) begin
      if (pc_load) begin
        pc <= pc_load_value;
      end else if (pc_inc) begin
        pc <= pc + 13'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt mask
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask <= 1'b1;
    end else if (state == cisl_pkg::ST_PUSH && step == `CISL_PUSH_LAST) begin
      int_mask <= 1'b1;
    end else if (state == cisl_pkg::ST_PULL && phase && step == 3'd0) begin
      int_mask <= mem_rdata[`CISL_CCR_I];
    end else if (idle) begin
      if (mask_set_instr) begin
        int_mask <= 1'b1;
      end else if (mask_clear_instr) begin
        int_mask <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Entry, vector and return sequencer
  // ----------------------------------------------------------------
  // Reset leaves in vector fetch so the start address is loaded first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cisl_pkg::ST_VEC;
      vec <= 13'(`CISL_VEC_RESET);
      step <= 3'd0;
      phase <= 1'b0;
      seq_busy <= 1'b1;
      mem_addr <= 13'h0000;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_wdata <= 8'h00;
      rest_a <= 8'h00;
      rest_x <= 8'h00;
      rest_flags <= 4'h0;
      restore_done <= 1'b0;
    end else begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      restore_done <= 1'b0;
      unique case (state)
        cisl_pkg::ST_IDLE: begin
          step <= 3'd0;
          phase <= 1'b0;
          if (take_hw || take_swi) begin
            state <= cisl_pkg::ST_PUSH;
            seq_busy <= 1'b1;
            if (take_swi) begin
              vec <= 13'(`CISL_VEC_SWI);
            end else if (hw_irq) begin
              vec <= 13'(`CISL_VEC_IRQ);
            end else begin
              vec <= 13'(`CISL_VEC_TIMER);
            end
          end else if (take_rti) begin
            state <= cisl_pkg::ST_PULL;
            seq_busy <= 1'b1;
          end
        end
        cisl_pkg::ST_PUSH: begin
          mem_wr <= 1'b1;
          mem_addr <= {`CISL_STACK_HI, sp};
          mem_wdata <= push_data;
          step <= step + 3'd1;
          if (step == `CISL_PUSH_LAST) begin
            state <= cisl_pkg::ST_VEC;
            step <= 3'd0;
          end
        end
        cisl_pkg::ST_VEC: begin
          if (!phase) begin
            mem_rd <= 1'b1;
            mem_addr <= vec | {12'h000, step[0]};
            phase <= 1'b1;
          end else begin
            phase <= 1'b0;
            step <= 3'd1;
            if (step == 3'd1) begin
              state <= cisl_pkg::ST_IDLE;
              step <= 3'd0;
              seq_busy <= 1'b0;
            end
          end
        end
        cisl_pkg::ST_PULL: begin
          if (!phase) begin
            mem_rd <= 1'b1;
            mem_addr <= {`CISL_STACK_HI, sp + 6'd1};
            phase <= 1'b1;
          end else begin
            phase <= 1'b0;
            step <= step + 3'd1;
            if (step == 3'd0) begin
              rest_flags <= {mem_rdata[`CISL_CCR_H], mem_rdata[2:0]};
            end
            if (step == 3'd1) begin
              rest_a <= mem_rdata;
            end
            if (step == 3'd2) begin
              rest_x <= mem_rdata;
            end
            if (step == `CISL_PULL_LAST) begin
              state <= cisl_pkg::ST_IDLE;
              step <= 3'd0;
              seq_busy <= 1'b0;
              restore_done <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Gives the service routine room to catch a fresh edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_cnt <= 4'd0;
    end else if (irq_hi_read) begin
      clr_cnt <= `CISL_LATCH_CLR_CYC;
    end else if (clr_cnt != 4'd0) begin
      clr_cnt <= clr_cnt - 4'd1;
    end
  end

  // ----------------------------------------------------------------
  // APB slave, one wait state
  // ----------------------------------------------------------------
  assign apb_acc = psel & penable & pready;
  assign apb_wr = apb_acc & pwrite & (paddr == `CISL_OFF_CTRL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_clr <= 1'b0;
      sw_sp_rst <= 1'b0;
    end else begin
      sw_clr <= apb_wr & pwdata[`CISL_CTRL_CLR];
      sw_sp_rst <= apb_wr & pwdata[`CISL_CTRL_SPRST];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && penable && !pready) begin
        if (paddr == `CISL_OFF_STAT) begin
          prdata <= {3'b000, seq_busy, irq_line, timer_req, hw_irq,
                     int_mask, 2'b00, sp, 3'b000, pc};
        end else if (paddr == `CISL_OFF_VEC) begin
          prdata <= {16'h0000, 3'b000, vec};
        end else if (paddr != `CISL_OFF_CTRL) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_five_pushes;
    mem_wr [*5] ##1 !mem_wr;
  endsequence
  sequence s_vec_fetch;
    mem_rd ##1 !mem_rd ##1 mem_rd ##1 !mem_rd;
  endsequence

  property p_sp_reset;
    @(posedge pclk) disable iff (!presetn)
      idle && stack_pointer_reset_instr |=> sp == `CISL_SP_RESET;
  endproperty
  a_sp_reset: assert property (p_sp_reset)
    else $error("stack pointer not reset");
  property p_push_dec;
    @(posedge pclk) disable iff (!presetn)
      state == cisl_pkg::ST_PUSH |=> sp == $past(sp) - 6'd1;
  endproperty
  a_push_dec: assert property (p_push_dec)
    else $error("push did not decrement");
  property p_stack_range;
    @(posedge pclk) disable iff (!presetn)
      mem_wr |-> mem_addr[12:6] == `CISL_STACK_HI;
  endproperty
  a_stack_range: assert property (p_stack_range)
    else $error("stack write outside page");
  property p_entry;
    @(posedge pclk) disable iff (!presetn)
      $rose(state == cisl_pkg::ST_PUSH) |=> s_five_pushes ##0 s_vec_fetch;
  endproperty
  a_entry: assert property (p_entry)
    else $error("entry sequence wrong");
  property p_mask_entry;
    @(posedge pclk) disable iff (!presetn)
      $rose(state == cisl_pkg::ST_VEC) |-> int_mask;
  endproperty
  a_mask_entry: assert property (p_mask_entry)
    else $error("mask not set on entry");
  property p_prio;
    @(posedge pclk) disable iff (!presetn)
      take_hw && hw_irq |=> vec == 13'(`CISL_VEC_IRQ);
  endproperty
  a_prio: assert property (p_prio)
    else $error("lower vector served first");
  property p_masked;
    @(posedge pclk) disable iff (!presetn)
      idle && int_mask && !software_trap_instr
      && !return_from_service_instr |=> state == cisl_pkg::ST_IDLE;
  endproperty
  a_masked: assert property (p_masked)
    else $error("masked request serviced");
  property p_swi;
    @(posedge pclk) disable iff (!presetn)
      idle && software_trap_instr && !instr_boundary
      |=> vec == 13'(`CISL_VEC_SWI) && state == cisl_pkg::ST_PUSH;
  endproperty
  a_swi: assert property (p_swi)
    else $error("software trap not taken");
  property p_latch_clr;
    @(posedge pclk) disable iff (!presetn)
      irq_hi_read |-> ##9 irq_bus.latch_clr;
  endproperty
  a_latch_clr: assert property (p_latch_clr)
    else $error("latch clear timing wrong");
  property p_rti;
    @(posedge pclk) disable iff (!presetn)
      take_rti |=> ##10 restore_done;
  endproperty
  a_rti: assert property (p_rti)
    else $error("return did not restore");
  property p_pc_inc;
    @(posedge pclk) disable iff (!presetn)
      idle && pc_inc && !pc_load |=> pc == $past(pc) + 13'd1;
  endproperty
  a_pc_inc: assert property (p_pc_inc)
    else $error("pc did not step");
endmodule : cisl_top
`default_nettype wire

// file: hw/cisl_params.svh
// Constants of the interrupt and stack sequencing block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef CISL_PARAMS_SVH
`define CISL_PARAMS_SVH
`define CISL_SP_RESET 6'h3f
`define CISL_STACK_HI 7'h03
`define CISL_VEC_RESET 16'h3ffe
`define CISL_VEC_SWI 16'h3ffc
`define CISL_VEC_IRQ 16'h3ffa
`define CISL_VEC_TIMER 16'h3ff8
`define CISL_LATCH_CLR_CYC 4'd9
`define CISL_PUSH_LAST 3'd4
`define CISL_PULL_LAST 3'd4
`define CISL_CCR_I 3
`define CISL_CCR_H 4
`define CISL_OFF_CTRL 8'h00
`define CISL_OFF_STAT 8'h04
`define CISL_OFF_VEC 8'h08
`define CISL_CTRL_CLR 0
`define CISL_CTRL_SPRST 1
`endif

// file: hw/cisl_pkg.sv
// Types shared by the interrupt and stack sequencing block.
// Assumes nothing of its surroundings.
package cisl_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_VEC, ST_PULL} cisl_state_e;
  typedef logic [12:0] cisl_addr_t;
endpackage : cisl_pkg

// file: hw/cisl_irq_if.sv
// Carrier between the sequencer and the external interrupt latch.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface cisl_irq_if;
  logic irq_n;
  logic [7:0] pa;
  logic [7:0] pa_out;
  logic [7:0] pa_en;
  logic edge_only;
  logic latch_clr;
  logic request;
  logic line;
  modport src (output irq_n, pa, pa_out, pa_en, edge_only, latch_clr,
               input request, line);
  modport latch (input irq_n, pa, pa_out, pa_en, edge_only, latch_clr,
                 output request, line);
endinterface : cisl_irq_if
`default_nettype wire

// file: hw/cisl_irq_latch.sv
// External interrupt latch: combines pin and port A, detects edges.
// Assumes pin inputs already synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
`include "cisl_params.svh"
module cisl_irq_latch (
  input wire logic clk,
  input wire logic rst_n,
  cisl_irq_if.latch bus
);
  logic [7:0] pa_act;
  logic comb;
  logic prev;
  logic latch;
  logic fall;

  assign pa_act = bus.pa_en & ~bus.pa_out;
  assign comb = bus.irq_n & (&(bus.pa | ~pa_act));
  assign fall = prev & ~comb;
  assign bus.line = comb;
  assign bus.request = bus.edge_only ? latch : (latch | ~comb);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b1;
    end else begin
      prev <= comb;
    end
  end

  // New edge beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch <= 1'b0;
    end else if (fall) begin
      latch <= 1'b1;
    end else if (bus.latch_clr) begin
      latch <= 1'b0;
    end
  end

  property p_edge_set;
    @(posedge clk) disable iff (!rst_n) fall |=> latch;
  endproperty
  a_edge_set: assert property (p_edge_set)
    else $error("edge did not set latch");
  property p_edge_only;
    @(posedge clk) disable iff (!rst_n)
      bus.edge_only && !latch |-> !bus.request;
  endproperty
  a_edge_only: assert property (p_edge_only)
    else $error("edge only mode followed level");
  property p_level;
    @(posedge clk) disable iff (!rst_n)
      !bus.edge_only && !comb |-> bus.request;
  endproperty
  a_level: assert property (p_level)
    else $error("low level gave no request");
endmodule : cisl_irq_latch
`default_nettype wire

// file: tb/cisl_mem_model.sv
// Memory seen by the sequencer: vector table plus stack page.
// Assumes one access per cycle and combinational read data.
`timescale 1ns/100ps
`default_nettype none
module cisl_mem_model (
  input wire logic pclk,
  input wire logic [12:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:8191];
  logic [7:0] last;
  // ---------------------------------------------
  // Vector table, high byte at even address
  // ---------------------------------------------
  initial begin
    mem[13'h1ffe] = 8'h01;
    mem[13'h1fff] = 8'h00;
    mem[13'h1ffc] = 8'h02;
    mem[13'h1ffd] = 8'h00;
    mem[13'h1ffa] = 8'h03;
    mem[13'h1ffb] = 8'h00;
    mem[13'h1ff8] = 8'h04;
    mem[13'h1ff9] = 8'h00;
    last = 8'h00;
  end
  // Plain always: the initial block also writes the array
  always @(posedge pclk) begin
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
    if (mem_rd) begin
      last <= mem[mem_addr];
    end
  end
  // Idle bus shows inverse of last byte so stale data cannot pass
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last;
endmodule : cisl_mem_model
`default_nettype wire

// file: tb/cisl_test.sv
// Self-checking bench of the interrupt and stack sequencing block.
// Assumes the memory model answers the sequencer's cycles.
`timescale 1ns/100ps
`default_nettype none
module cisl_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, irq_n = 1'b1, cmf = 1'b0;
  logic eo = 1'b0;
  // Bits: cap flag, cap enable, compare enable, wrap flag, wrap enable
  logic [4:0] tim = 5'h04;
  logic [7:0] pa = 8'hff, ddr = 8'h00, mrd, mwd, ra;
  // Bits: bnd sprst swi rti push pull inc load mset mclr
  logic [9:0] ctl = 10'h0;
  logic [12:0] pcv = 13'h0, pc, sa, maddr;
  logic imask, busy, line, mr, mw;
  int error_cnt = 0, compares = 0;
  always #5 pclk = ~pclk;
  cisl_top cisl_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_n_pin(irq_n), .port_a_pins(pa), .port_a_ddr(ddr),
    .option_byte_two(8'h01), .edge_only_opt(eo),
    .capture_event_flag(tim[0]), .compare_match_flag(cmf),
    .counter_wrap_flag(tim[3]), .capture_ie(tim[1]), .compare_ie(tim[2]),
    .wrap_ie(tim[4]), .instr_boundary(ctl[0]),
    .stack_pointer_reset_instr(ctl[1]), .software_trap_instr(ctl[2]),
    .return_from_service_instr(ctl[3]), .push_byte(ctl[4]),
    .pull_byte(ctl[5]), .pc_inc(ctl[6]), .pc_load(ctl[7]),
    .pc_load_value(pcv), .mask_set_instr(ctl[8]),
    .mask_clear_instr(ctl[9]), .cpu_a(8'h5a), .cpu_x(8'h3c),
    .cpu_flags(4'h5), .mem_rdata(mrd), .pc(pc), .stack_addr(sa),
    .int_mask(imask), .seq_busy(busy), .irq_line(line), .mem_addr(maddr),
    .mem_rd(mr), .mem_wr(mw), .mem_wdata(mwd), .rest_a(ra), .rest_x(),
    .rest_flags(), .restore_done());
  cisl_mem_model cisl_mem_model_inst (.pclk(pclk), .mem_addr(maddr),
    .mem_rd(mr), .mem_wr(mw), .mem_wdata(mwd), .mem_rdata(mrd));
  // ---------------------------------------------
  // Shared tasks
  // ---------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic wait_idle;
    int n;
    for (n = 0; n < 40; n++) begin
      @(negedge pclk);
      if (busy === 1'b0) break;
    end
    if (n == 40) chk(busy, 0);
  endtask : wait_idle
  task automatic pulse(input int k);
    @(posedge pclk) ctl <= 10'h1 << k;
    @(posedge pclk) ctl <= 10'h0;
    @(posedge pclk);
    wait_idle();
  endtask : pulse
  // Holds the request until pready is seen high or 20 cycles pass, then releases
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    stop_test();
  end
  // ---------------------------------------------
  // Tests
  // ---------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wait_idle();
    chk(pc, 32'h100);
    chk(imask, 1);
    chk(sa, 32'h0ff);
    apb(1'b0, 8'h04, 32'h0);
    chk(r, 32'h093f_0100);
    apb(1'b0, 8'h0c, 32'h0);
    chk({e, r[30:0]}, 32'h8000_0000);
    $display("test reset done");
    pcv <= 13'h1fff;
    pulse(7);
    pulse(6);
    chk(pc, 32'h0);
    @(posedge pclk) pcv <= 13'h0100;
    pulse(7);
    pulse(4);
    chk(sa, 32'h0fe);
    pulse(5);
    chk(sa, 32'h0ff);
    repeat (64) pulse(4);
    chk(sa, 32'h0ff);
    pulse(4);
    apb(1'b1, 8'h00, 32'h2);
    repeat (2) @(negedge pclk);
    chk(sa, 32'h0ff);
    pulse(4);
    pulse(1);
    chk(sa, 32'h0ff);
    $display("test stack done");
    @(posedge pclk) irq_n <= 1'b0;
    repeat (3) @(posedge pclk);
    pulse(0);
    chk(pc, 32'h100);
    pulse(9);
    pulse(0);
    @(posedge pclk) irq_n <= 1'b1;
    chk(pc, 32'h300);
    chk(imask, 1);
    chk(sa, 32'h0fa);
    chk(cisl_mem_model_inst.mem[13'h0fc], 32'h5a);
    repeat (10) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    chk(r[25], 0);
    pulse(3);
    chk(pc, 32'h100);
    chk(sa, 32'h0ff);
    chk(ra, 32'h5a);
    chk(imask, 0);
    $display("test irq done");
    @(posedge pclk) cmf <= 1'b1;
    irq_n <= 1'b0;
    repeat (3) @(posedge pclk);
    pulse(0);
    @(posedge pclk) irq_n <= 1'b1;
    chk(pc, 32'h300);
    repeat (10) @(posedge pclk);
    pulse(3);
    pulse(0);
    chk(pc, 32'h400);
    @(posedge pclk) cmf <= 1'b0;
    pulse(3);
    pulse(8);
    pulse(2);
    chk(pc, 32'h200);
    pulse(3);
    chk(imask, 1);
    $display("test priority done");
    @(posedge pclk) tim <= 5'h05;
    pulse(9);
    pulse(0);
    chk(pc, 32'h100);
    @(posedge pclk) tim <= 5'h1c;
    pulse(0);
    chk(pc, 32'h400);
    @(posedge pclk) tim <= 5'h04;
    pulse(3);
    chk(pc, 32'h100);
    $display("test timer done");
    @(posedge pclk) pa[0] <= 1'b0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk(line, 0);
    @(posedge pclk) ddr[0] <= 1'b1;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk(line, 1);
    $display("test port done");
    // Second reset in mid-run picks up the edge only option
    @(posedge pclk) presetn <= 1'b0;
    eo <= 1'b1;
    pa <= 8'hff;
    ddr <= 8'h00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_idle();
    chk(pc, 32'h100);
    chk(imask, 1);
    pulse(9);
    @(posedge pclk) irq_n <= 1'b0;
    pulse(0);
    chk(pc, 32'h300);
    repeat (10) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    chk(r[25], 0);
    chk(r[27], 0);
    @(posedge pclk) irq_n <= 1'b1;
    pulse(3);
    chk(pc, 32'h100);
    $display("test edge mode done");
    stop_test();
  end
endmodule : cisl_test
`default_nettype wire
